// *** core/fic_pkg.sv ***
package fic_pkg;

   // ---------------------------------------------------------------
   // register map of the control slice
   // ---------------------------------------------------------------
   localparam logic [8:0] FIC_OFS_ALARM2   = 9'h00D;
   localparam logic [8:0] FIC_OFS_ERROR    = 9'h00E;
   localparam logic [8:0] FIC_OFS_CNT_OVF  = 9'h00F;
   localparam logic [8:0] FIC_OFS_TIMER    = 9'h010;
   localparam logic [8:0] FIC_OFS_DLINK1   = 9'h011;
   localparam logic [8:0] FIC_OFS_DLINK2   = 9'h012;
   localparam logic [8:0] FIC_OFS_PATTERN  = 9'h013;
   localparam logic [8:0] FIC_OFS_LOOP     = 9'h014;
   localparam logic [8:0] FIC_OFS_SLOT     = 9'h015;
   localparam int         FIC_NREG         = 9;
   localparam int         FIC_NIRQ         = 7;
   localparam logic [7:0] FIC_REG_RST      = 8'h00;
   localparam logic [7:0] FIC_RD_UNMAPPED  = 8'h00;

   // writable bits per register, reserved bits read zero
   localparam logic [FIC_NREG-1:0][7:0] FIC_WMASK = {
      8'hFF, 8'h0E, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hCF, 8'hEB};

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int FIC_LOOP_PAYLOAD = 3;
   localparam int FIC_LOOP_LINE    = 2;
   localparam int FIC_LOOP_FRAMER  = 1;
   localparam int FIC_EXT_EN       = 7;
   localparam int FIC_EXT_ODD      = 6;
   localparam int FIC_EXT_EVEN     = 5;
   localparam int FIC_TS_MSB       = 4;
   localparam logic [4:0] FIC_TS_FBITS = 5'h00;
   localparam int FIC_SYNC_STAGES  = 3;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic pos;
      logic neg;
   } fic_rail_s;

   typedef struct packed {
      logic [4:0] frame;   // frame number within multiframe
      logic [4:0] slot;    // time slot (channel number in T1)
      logic [2:0] bitn;    // bit within slot, 0 = first sent
      logic       fbit;    // T1 framing bit time
   } fic_pos_s;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // true when the position falls on a selected external link bit
   function automatic logic ext_hit(
      input logic [7:0] sel,
      input logic       t1,
      input fic_pos_s   p,
      input logic [7:0] mask);
      logic par_ok;
      par_ok = p.frame[0] ? sel[FIC_EXT_ODD] : sel[FIC_EXT_EVEN];
      ext_hit = 1'b0;
      if (!sel[FIC_EXT_EN])
         ext_hit = 1'b0;
      else if (t1 && sel[FIC_TS_MSB:0] == FIC_TS_FBITS)
         ext_hit = p.fbit;
      else if (p.fbit)
         ext_hit = 1'b0;
      else
         ext_hit = par_ok && p.slot == sel[FIC_TS_MSB:0]
                   && mask[p.bitn];
   endfunction : ext_hit

   // write value with reserved bits forced low
   function automatic logic [7:0] masked(
      input int         ix,
      input logic [7:0] v);
      masked = v & FIC_WMASK[ix];
   endfunction : masked

endpackage : fic_pkg

// *** core/fic_frame_mem.sv ***
`timescale 1ns/100ps
// one-bit-wide frame store for the payload loop path
module fic_frame_mem
   import fic_pkg::*;
#(
   parameter int AW = 8
)(
   input  wire logic          mclk,
   input  wire logic          arst_n,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic          wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output      logic          rd_data
);

   typedef struct packed {
      logic [(1<<AW)-1:0] mem;
      logic               rd;
   } fic_mem_s;

   fic_mem_s r;
   fic_mem_s next_r;

   // write when wr_en is set, registered read every cycle
   always_comb
   begin
      next_r = r;
      if (wr_en)
      begin
         next_r.mem[wr_addr] = wr_data;
      end
      next_r.rd = r.mem[rd_addr];
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         r <= '0;
      else
         r <= next_r;
   end

   assign rd_data = r.rd;

endmodule : fic_frame_mem

// *** core/fic_ctrl.sv ***
// Operation
// - enable bit gates source onto summary flag
// - counter saturates, or wraps and flags
// - latch on low read, clear on high
// - payload loop sends received payload, same slot
// - overhead source and tx timing unchanged
// - async clocks slip silently in loop
// - forced idle overrides payload loop
// - line loop sends rx rails to tx
// - line and framer loops together
// - framer loop feeds encoder to decoder
// - link enable gates insertion and clocks
// - frame select none, even, odd, all
// - frame parity counted per line mode
// - slot field picks slot or F bits
// - F bit slot ignores frame parity
// - rx link data carries whole stream
// - bit mask picks pulsed bits, LSB first
`timescale 1ns/100ps
module fic_ctrl
   import fic_pkg::*;
#(
   parameter int NCNT = 8,
   parameter int CW   = 16
)(
   input  wire logic                         mclk,
   input  wire logic                         arst_n,
   input  wire logic                         cpu_cs,
   input  wire logic                         cpu_wr,
   input  wire logic                         cpu_rd,
   input  wire logic [8:0]                   cpu_addr,
   input  wire logic [7:0]                   cpu_wdata,
   output      logic [7:0]                   cpu_rdata,
   input  wire logic [FIC_NIRQ-1:0][7:0]     irq_src,
   output      logic                         summary_irq_flag,
   input  wire logic [NCNT-1:0]              err_evt,
   input  wire logic                         one_sec,
   input  wire logic                         count_latch_mode,
   input  wire logic [$clog2(NCNT)-1:0]      cnt_sel,
   input  wire logic                         cnt_rd_lo,
   input  wire logic                         cnt_rd_hi,
   output      logic [7:0]                   cnt_rdata,
   input  wire logic                         rx_pos_rail_in,
   input  wire logic                         rx_neg_rail_in,
   input  wire fic_rail_s                    enc_rail,
   output      logic                         tx_pos_rail_out,
   output      logic                         tx_neg_rail_out,
   output      fic_rail_s                    dec_rail,
   output      logic                         rx_clk_loop_sel,
   input  wire logic                         t1_mode,
   input  wire logic                         rx_strobe,
   input  wire fic_pos_s                     rx_pos,
   input  wire logic                         rx_pl_bit,
   input  wire logic                         tx_strobe,
   input  wire fic_pos_s                     tx_pos,
   input  wire logic                         tx_pl_bit,
   input  wire logic                         tx_oh_time,
   input  wire logic                         tx_overhead_source,
   input  wire logic                         tx_fmt_oh_bit,
   input  wire logic                         tx_bus_oh_bit,
   input  wire logic                         channel_idle_force,
   input  wire logic                         idle_code_bit,
   input  wire logic [7:0]                   ext_link_bit_mask,
   input  wire logic                         ext_tx_data_in,
   output      logic                         tx_bit_out,
   output      logic                         ext_tx_clk_out,
   output      logic                         ext_rx_clk_out,
   output      logic                         ext_rx_data_out
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (CW < 9 || CW > 16)
      $error("counter width must be 9 to 16");
   if (NCNT < 2 || NCNT > 8)
      $error("counter count must be 2 to 8");

   localparam int LOOP_IX = int'(FIC_OFS_LOOP - FIC_OFS_ALARM2);
   localparam int SLOT_IX = int'(FIC_OFS_SLOT - FIC_OFS_ALARM2);
   localparam int OVF_IX  = int'(FIC_OFS_CNT_OVF - FIC_OFS_ALARM2);
   localparam logic [CW-1:0] CNT_ONES = '1;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [FIC_NREG-1:0][7:0]  bank;
      logic [7:0]                rdata;
      logic [7:0]                cnt_rdata;
      logic [NCNT-1:0][CW-1:0]   cnt;
      logic [NCNT-1:0][CW-1:0]   lat;
      logic [2:0]                sy0;
      logic [2:0]                sy1;
      logic [2:0]                sy2;
      logic [2:0]                flt;
      logic                      irq;
      fic_rail_s                 tx_rail;
      fic_rail_s                 dec_rail;
      logic                      rx_clk_sel;
      logic                      tx_bit;
      logic                      ext_tx_clock_select;
      logic                      ext_rxclk;
      logic                      ext_rxdata;
   } fic_top_s;

   fic_top_s r;
   fic_top_s next_r;

   logic     loop_rd;
   logic     tx_hit;
   logic     rx_hit;
   logic     payload_loop_en;
   logic     line_loop_en;
   logic     framer_loop_en;
   logic     ext_link_en;
   logic [4:0] slot_index;

   // ---------------------------------------------------------------
   // decoded control bits
   // ---------------------------------------------------------------
   assign payload_loop_en = r.bank[LOOP_IX][FIC_LOOP_PAYLOAD];
   assign line_loop_en    = r.bank[LOOP_IX][FIC_LOOP_LINE];
   assign framer_loop_en  = r.bank[LOOP_IX][FIC_LOOP_FRAMER];
   assign ext_link_en     = r.bank[SLOT_IX][FIC_EXT_EN];
   assign slot_index      = r.bank[SLOT_IX][FIC_TS_MSB:0];
   assign tx_hit = ext_hit(r.bank[SLOT_IX], t1_mode, tx_pos,
                           ext_link_bit_mask);
   assign rx_hit = ext_hit(r.bank[SLOT_IX], t1_mode, rx_pos,
                           ext_link_bit_mask);

   // ---------------------------------------------------------------
   // payload loop store
   // ---------------------------------------------------------------
   // one frame of receive payload; overwrite or reread of a frame is
   // the controlled slip when rx and tx clocks drift, never reported
   fic_frame_mem #(
      .AW (8)
   ) u_frame_mem (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .wr_en   (rx_strobe && !rx_pos.fbit),
      .wr_addr ({rx_pos.slot, rx_pos.bitn}),
      .wr_data (rx_pl_bit),
      .rd_addr ({tx_pos.slot, tx_pos.bitn}),
      .rd_data (loop_rd)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic             roll;
      logic [CW-1:0]    base;
      logic             clr;
      int               ix;
      next_r = r;
      roll   = 1'b0;
      base   = '0;
      clr    = 1'b0;
      ix     = int'(cpu_addr - FIC_OFS_ALARM2);

      // processor port, writes land one edge later
      if (cpu_cs && cpu_wr && cpu_addr >= FIC_OFS_ALARM2
          && cpu_addr <= FIC_OFS_SLOT)
      begin
         next_r.bank[ix] = masked(ix, cpu_wdata);
      end
      if (cpu_cs && cpu_rd && cpu_addr >= FIC_OFS_ALARM2
          && cpu_addr <= FIC_OFS_SLOT)
      begin
         next_r.rdata = r.bank[ix];
      end
      else if (cpu_cs && cpu_rd)
      begin
         next_r.rdata = FIC_RD_UNMAPPED;
      end

      // error counters; a count in the clearing cycle still counts
      for (int i = 0; i < NCNT; i++)
      begin
         clr  = !count_latch_mode && cnt_rd_hi
                && int'(cnt_sel) == i;
         base = clr ? '0 : r.cnt[i];
         if (err_evt[i])
         begin
            if (base == CNT_ONES && !r.bank[OVF_IX][i])
               next_r.cnt[i] = base;
            else
               next_r.cnt[i] = base + 1'b1;
            if (base == CNT_ONES && r.bank[OVF_IX][i])
               roll = 1'b1;
         end
         else
         begin
            next_r.cnt[i] = base;
         end
         if (count_latch_mode ? one_sec
             : (cnt_rd_lo && int'(cnt_sel) == i))
         begin
            next_r.lat[i] = r.cnt[i];
         end
      end
      if (cnt_rd_lo)
      begin
         next_r.cnt_rdata = count_latch_mode ? r.lat[cnt_sel][7:0]
                            : r.cnt[cnt_sel][7:0];
      end
      else if (cnt_rd_hi)
      begin
         next_r.cnt_rdata = 8'(r.lat[cnt_sel][CW-1:8]);
      end

      // summary flag: a disabled source still reaches its own status
      // elsewhere, but never this flag
      next_r.irq = roll;
      for (int k = 0; k < FIC_NIRQ; k++)
      begin
         if (|(irq_src[k] & r.bank[k]))
            next_r.irq = 1'b1;
      end

      // pin synchronisers, a change counts once stages two and three
      // agree, so a single-cycle glitch never reaches the rails
      next_r.sy0 = {ext_tx_data_in, rx_neg_rail_in, rx_pos_rail_in};
      next_r.sy1 = r.sy0;
      next_r.sy2 = r.sy1;
      for (int b = 0; b < FIC_SYNC_STAGES; b++)
      begin
         if (r.sy1[b] == r.sy2[b])
            next_r.flt[b] = r.sy2[b];
      end

      // line and framer loops are independent, both may be on
      next_r.tx_rail = line_loop_en ? fic_rail_s'({r.flt[0], r.flt[1]})
                       : enc_rail;
      next_r.dec_rail = framer_loop_en ? enc_rail
                        : fic_rail_s'({r.flt[0], r.flt[1]});
      next_r.rx_clk_sel = framer_loop_en;

      // transmit bit select; tx timing comes only from tx strobes so
      // switching the payload loop never moves frame alignment
      if (tx_strobe)
      begin
         if (tx_hit)
            next_r.tx_bit = r.flt[2];
         else if (tx_oh_time)
            next_r.tx_bit = tx_overhead_source ? tx_bus_oh_bit
                            : tx_fmt_oh_bit;
         else if (channel_idle_force)
            next_r.tx_bit = idle_code_bit;
         else if (payload_loop_en)
            next_r.tx_bit = loop_rd;
         else
            next_r.tx_bit = tx_pl_bit;
      end

      // external link clocks pulse for one cycle per selected bit
      next_r.ext_tx_clock_select = tx_strobe && tx_hit;
      next_r.ext_rxclk = rx_strobe && rx_hit;
      if (!ext_link_en || (r.bank[SLOT_IX][FIC_EXT_ODD:FIC_EXT_EVEN] == '0
          && !(t1_mode && slot_index == FIC_TS_FBITS)))
         next_r.ext_rxdata = 1'b0;
      else if (rx_strobe)
         next_r.ext_rxdata = rx_pl_bit;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r <= '0;
         r.bank <= {FIC_NREG{FIC_REG_RST}};
      end
      else
         r <= next_r;
   end

   // outputs straight from flops
   assign cpu_rdata        = r.rdata;
   assign cnt_rdata        = r.cnt_rdata;
   assign summary_irq_flag = r.irq;
   assign tx_pos_rail_out  = r.tx_rail.pos;
   assign tx_neg_rail_out  = r.tx_rail.neg;
   assign dec_rail         = r.dec_rail;
   assign rx_clk_loop_sel  = r.rx_clk_sel;
   assign tx_bit_out       = r.tx_bit;
   assign ext_tx_clk_out   = r.ext_tx_clock_select;
   assign ext_rx_clk_out   = r.ext_rxclk;
   assign ext_rx_data_out  = r.ext_rxdata;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   a_irq_gate: assert property (
      |(irq_src[0] & r.bank[0]) |=> summary_irq_flag)
      else $error("enabled source did not raise summary flag");
   a_irq_block: assert property (
      (irq_src == '0 && err_evt == '0) |=> !summary_irq_flag)
      else $error("summary flag raised without a source");
   a_cnt_sat: assert property (
      err_evt[0] && !r.bank[OVF_IX][0] && r.cnt[0] == CNT_ONES
      && !(cnt_rd_hi && cnt_sel == '0)
      |=> r.cnt[0] == CNT_ONES)
      else $error("counter did not saturate");
   a_cnt_wrap: assert property (
      err_evt[0] && r.bank[OVF_IX][0] && r.cnt[0] == CNT_ONES
      && !(cnt_rd_hi && cnt_sel == '0)
      |=> r.cnt[0] == '0 && summary_irq_flag)
      else $error("counter rollover missed");
   a_rd_clear: assert property (
      !count_latch_mode && cnt_rd_hi && cnt_sel == '0 && !err_evt[0]
      |=> r.cnt[0] == '0)
      else $error("high byte read did not clear counter");
   a_sec_latch: assert property (
      count_latch_mode && one_sec |=> r.lat[1] == $past(r.cnt[1]))
      else $error("one second latch missed");
   a_line_loop: assert property (
      line_loop_en |=> tx_pos_rail_out == $past(r.flt[0])
      && tx_neg_rail_out == $past(r.flt[1]))
      else $error("line loop rails wrong");
   a_framer_loop: assert property (
      framer_loop_en && !(cpu_cs && cpu_wr)
      |=> dec_rail == $past(enc_rail) && rx_clk_loop_sel)
      else $error("framer loop rails wrong");
   a_ext_off: assert property (
      !ext_link_en |=> !ext_tx_clk_out && !ext_rx_clk_out)
      else $error("link clock pulsed while disabled");
   a_idle_wins: assert property (
      tx_strobe && channel_idle_force && !tx_hit && !tx_oh_time
      |=> tx_bit_out == $past(idle_code_bit))
      else $error("idle did not override payload");
   a_reg_rdbk: assert property (
      cpu_cs && cpu_wr && cpu_addr == FIC_OFS_LOOP ##1 !cpu_cs
      ##1 cpu_cs && cpu_rd && cpu_addr == FIC_OFS_LOOP && !cpu_wr
      |=> cpu_rdata == ($past(cpu_wdata, 3) & FIC_WMASK[LOOP_IX]))
      else $error("loopback register read back wrong");
   c_payload_loop: cover property (
      payload_loop_en && tx_strobe && !tx_oh_time);
   c_ext_hit: cover property (tx_strobe && tx_hit);
   c_cnt_wrap: cover property (
      err_evt[0] && r.bank[OVF_IX][0] && r.cnt[0] == CNT_ONES);
   c_both_loops: cover property (line_loop_en && framer_loop_en);

endmodule : fic_ctrl

// *** testbench/fic_lif.sv ***
`timescale 1ns/100ps
// ------------------------------------------------
// line unit and transmit bus stand-in, e1 timing
// ------------------------------------------------
module fic_lif
   import fic_pkg::*;
(
   input  wire logic mclk,
   input  wire logic arst_n,
   output logic      strobe,
   output fic_pos_s  pos,
   output logic      rx_pl_bit,
   output logic      tx_pl_bit,
   output logic      tx_oh_time,
   output logic      tx_fmt_oh_bit,
   output logic      tx_bus_oh_bit,
   output logic      channel_idle_force,
   output logic      idle_code_bit,
   output logic      rx_pos_rail_in,
   output logic      rx_neg_rail_in,
   output logic      ext_tx_data_in
);
   logic [1:0]  ph;
   logic [11:0] cnt;

   // one bit every four clocks; position moves only after its strobe
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ph     <= 2'h0;
         cnt    <= 12'h000;
         strobe <= 1'b0;
      end
      else
      begin
         ph     <= ph + 2'h1;
         strobe <= (ph == 2'h2);
         if (strobe)
            cnt <= cnt + 12'h001;
      end
   end

   // rx and tx share one timebase, so the receive clock is looped
   // pin functions taken as routed to the external link pins
   // payload hangs on slot and bit only, so a frame-late loop matches
   assign pos                = {1'b0, cnt, 1'b0};
   assign rx_pl_bit          = cnt[4] ^ cnt[0];
   assign tx_pl_bit          = cnt[1];
   assign tx_oh_time         = (cnt[7:3] == 5'h00);
   assign tx_fmt_oh_bit      = cnt[0];
   assign tx_bus_oh_bit      = ~cnt[0];
   assign channel_idle_force = (cnt[7:3] == 5'h05);
   assign idle_code_bit      = ~cnt[2];
   assign rx_pos_rail_in     = cnt[4];
   assign rx_neg_rail_in     = cnt[5];
   // link bit held whole frames, long settled before sampling
   assign ext_tx_data_in     = cnt[9];
endmodule : fic_lif

// *** testbench/fic_ctrl_tb.sv ***
`timescale 1ns/100ps
// ------------------------------------------------
// control slice bench
// ------------------------------------------------
module fic_ctrl_tb
   import fic_pkg::*;
;
   logic  mclk, arst_n, cpu_cs, cpu_wr, cpu_rd, one_sec, count_latch_mode;
   logic  cnt_rd_lo, cnt_rd_hi, t1_mode, tx_overhead_source, chk, pend;
   logic  strobe, rx_pl_bit, tx_pl_bit, tx_oh_time, tx_fmt_oh_bit, eh, eb;
   logic  tx_bus_oh_bit, channel_idle_force, idle_code_bit, er;
   logic  rx_pos_rail_in, rx_neg_rail_in, ext_tx_data_in, summary_irq_flag;
   logic  tx_pos_rail_out, tx_neg_rail_out, rx_clk_loop_sel, tx_bit_out;
   logic  ext_tx_clk_out, ext_rx_clk_out, ext_rx_data_out;
   logic  [8:0]  cpu_addr;
   logic  [7:0]  cpu_wdata, cpu_rdata, err_evt, cnt_rdata, lp, sl, b8;
   logic  [7:0]  ext_link_bit_mask;
   logic  [2:0]  cnt_sel;
   logic  [15:0] v16;
   logic  [FIC_NIRQ-1:0][7:0] irq_src;
   fic_rail_s    enc_rail, dec_rail, rails, txr;
   fic_pos_s     pos;
   int           miscompares, check_count, irqn, n0;

   assign rails = {rx_pos_rail_in, rx_neg_rail_in};
   assign txr   = {tx_pos_rail_out, tx_neg_rail_out};

   fic_ctrl #(.NCNT(8), .CW(9)) DUT (
      .mclk, .arst_n, .cpu_cs, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata,
      .cpu_rdata, .irq_src, .summary_irq_flag, .err_evt, .one_sec,
      .count_latch_mode, .cnt_sel, .cnt_rd_lo, .cnt_rd_hi, .cnt_rdata,
      .rx_pos_rail_in, .rx_neg_rail_in, .enc_rail, .tx_pos_rail_out,
      .tx_neg_rail_out, .dec_rail, .rx_clk_loop_sel, .t1_mode,
      .rx_strobe(strobe), .rx_pos(pos), .rx_pl_bit, .tx_strobe(strobe),
      .tx_pos(pos), .tx_pl_bit, .tx_oh_time, .tx_overhead_source,
      .tx_fmt_oh_bit, .tx_bus_oh_bit, .channel_idle_force, .idle_code_bit,
      .ext_link_bit_mask, .ext_tx_data_in, .tx_bit_out, .ext_tx_clk_out,
      .ext_rx_clk_out, .ext_rx_data_out
   );

   fic_lif u_partner (
      .mclk, .arst_n, .strobe, .pos, .rx_pl_bit, .tx_pl_bit, .tx_oh_time,
      .tx_fmt_oh_bit, .tx_bus_oh_bit, .channel_idle_force, .idle_code_bit,
      .rx_pos_rail_in, .rx_neg_rail_in, .ext_tx_data_in
   );

   // 200 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // one register access; read data lands one edge after the request
   task automatic cpu(input logic w, input logic [8:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk);
      cpu_cs    <= 1'b1;
      cpu_wr    <= w;
      cpu_rd    <= ~w;
      cpu_addr  <= a;
      cpu_wdata <= d;
      @(posedge mclk);
      cpu_cs <= 1'b0;
      cpu_wr <= 1'b0;
      cpu_rd <= 1'b0;
      #1 q = cpu_rdata;
   endtask : cpu

   // low byte then high byte of the same latch
   task automatic cnt_rd(input logic [2:0] s, output logic [15:0] q);
      @(posedge mclk);
      cnt_sel   <= s;
      cnt_rd_lo <= 1'b1;
      @(posedge mclk);
      cnt_rd_lo <= 1'b0;
      cnt_rd_hi <= 1'b1;
      #1 q[7:0] = cnt_rdata;
      @(posedge mclk);
      cnt_rd_hi <= 1'b0;
      #1 q[15:8] = cnt_rdata;
   endtask : cnt_rd

   task automatic ev(input logic [2:0] s, input int n);
      @(posedge mclk);
      err_evt <= 8'h01 << s;
      repeat (n) @(posedge mclk);
      err_evt <= 8'h00;
   endtask : ev

   task automatic tick;
      @(posedge mclk);
      one_sec <= 1'b1;
      @(posedge mclk);
      one_sec <= 1'b0;
   endtask : tick

   task automatic pulse(input int i, input int b);
      @(posedge mclk);
      irq_src[i][b] <= 1'b1;
      @(posedge mclk);
      irq_src[i][b] <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : pulse

   // reconfigure, let one frame settle, then score one frame
   task automatic phase(input logic [7:0] l, input logic [7:0] s,
                        input logic [7:0] m, input logic o);
      chk <= 1'b0;
      cpu(1'b1, FIC_OFS_LOOP, l, b8);
      cpu(1'b1, FIC_OFS_SLOT, s, b8);
      lp                 <= l;
      sl                 <= s;
      ext_link_bit_mask  <= m;
      tx_overhead_source <= o;
      enc_rail           <= {o, ~o};
      repeat (1024) @(posedge mclk);
      chk <= 1'b1;
      repeat (1024) @(posedge mclk);
   endtask : phase

   // scoreboard at every bit strobe of a scoring frame, and summary pulse count
   always @(posedge mclk)
   begin
      if (summary_irq_flag === 1'b1)
         irqn++;
      if (pend)
      begin
         check(tx_bit_out, eb);
         check(ext_tx_clk_out, eh);
         check(ext_rx_clk_out, eh);
         check(ext_rx_data_out, er);
      end
      pend = chk & strobe;
      if (pend)
      begin
         eh = sl[7] & ((t1_mode && sl[4:0] == 5'h00) ? pos.fbit
            : !pos.fbit & (pos.frame[0] ? sl[6] : sl[5])
            & (pos.slot == sl[4:0]) & ext_link_bit_mask[pos.bitn]);
         er = sl[7] & (|sl[6:5] | (t1_mode && sl[4:0] == 5'h00))
            & rx_pl_bit;
         eb = eh ? ext_tx_data_in
            : tx_oh_time ? (tx_overhead_source ? tx_bus_oh_bit : tx_fmt_oh_bit)
            : channel_idle_force ? idle_code_bit
            : lp[3] ? rx_pl_bit : tx_pl_bit;
         if (pos.bitn[2:1] != 2'h0)
         begin
            check(txr, lp[2] ? rails : enc_rail);
            check(dec_rail, lp[1] ? enc_rail : rails);
            check(rx_clk_loop_sel, lp[1]);
         end
      end
   end

   // hang guard, a little over twice the planned run
   initial
   begin
      #300000;
      miscompares++;
      report_and_stop;
   end

   initial
   begin
      arst_n = 1'b0;
      {cpu_cs, cpu_wr, cpu_rd, one_sec, count_latch_mode, cnt_rd_lo} = '0;
      {cnt_rd_hi, t1_mode, tx_overhead_source, chk, pend} = '0;
      {cpu_addr, cpu_wdata, err_evt, lp, sl, ext_link_bit_mask} = '0;
      {cnt_sel, enc_rail, irq_src} = '0;
      {miscompares, check_count, irqn} = '0;
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      for (int i = 0; i < FIC_NREG; i++)
      begin
         cpu(1'b0, FIC_OFS_ALARM2 + 9'(i), 8'h00, b8);
         check(b8, FIC_REG_RST);
         cpu(1'b1, FIC_OFS_ALARM2 + 9'(i), 8'hFF, b8);
         cpu(1'b0, FIC_OFS_ALARM2 + 9'(i), 8'h00, b8);
         check(b8, FIC_WMASK[i]);
         cpu(1'b1, FIC_OFS_ALARM2 + 9'(i), 8'h00, b8);
      end
      cpu(1'b1, 9'h016, 8'hFF, b8);
      cpu(1'b0, 9'h016, 8'h00, b8);
      check(b8, FIC_RD_UNMAPPED);
      $display("test registers finished");
      for (int i = 0; i < FIC_NIRQ; i++)
      begin
         cpu(1'b1, FIC_OFS_ALARM2 + 9'(i), 8'h02, b8);
         n0 = irqn;
         pulse(i, 1);
         check(16'(irqn - n0), 16'h0001);
         pulse(i, 0);
         check(16'(irqn - n0), 16'h0001);
         cpu(1'b1, FIC_OFS_ALARM2 + 9'(i), 8'h00, b8);
      end
      $display("test interrupts finished");
      for (int i = 0; i < 8; i++)
      begin
         ev(3'(i), 7);
         cnt_rd(3'(i), v16);
         check(v16, 16'h0007);
         cnt_rd(3'(i), v16);
         check(v16, 16'h0000);
      end
      n0 = irqn;
      ev(3'h0, 512);
      cnt_rd(3'h0, v16);
      check(v16, 16'h01FF);
      cpu(1'b1, FIC_OFS_CNT_OVF, 8'h01, b8);
      ev(3'h0, 512);
      cnt_rd(3'h0, v16);
      check(v16, 16'h0000);
      check(16'(irqn - n0), 16'h0001);
      count_latch_mode <= 1'b1;
      tick;
      ev(3'h0, 5);
      tick;
      cnt_rd(3'h0, v16);
      check(v16, 16'h0005);
      ev(3'h0, 3);
      cnt_rd(3'h0, v16);
      check(v16, 16'h0005);
      tick;
      cnt_rd(3'h0, v16);
      check(v16, 16'h0008);
      $display("test counters finished");
      phase(8'h00, 8'h00, 8'h00, 1'b0);
      phase(8'h08, 8'h00, 8'h00, 1'b0);
      phase(8'h08, 8'h00, 8'h00, 1'b1);
      phase(8'h04, 8'h63, 8'hFF, 1'b1);
      phase(8'h02, 8'h00, 8'h00, 1'b0);
      phase(8'h06, 8'hE3, 8'hA5, 1'b0);
      phase(8'h08, 8'hC3, 8'h5A, 1'b1);
      phase(8'h00, 8'hA3, 8'h81, 1'b0);
      phase(8'h00, 8'h83, 8'hFF, 1'b0);
      phase(8'h08, 8'hE5, 8'hFF, 1'b1);
      phase(8'h08, 8'hE0, 8'hFF, 1'b0);
      t1_mode <= 1'b1;
      phase(8'h08, 8'h80, 8'hFF, 1'b0);
      $display("test loops and link finished");
      report_and_stop;
   end
endmodule : fic_ctrl_tb
